// ===== ctrl_word_tx_pkg.sv
// Constants for the control word transmit table access block
package ctrl_word_tx_pkg;
  localparam int DATA_W = 32;
  localparam int ADDR_W = 12;
  localparam logic [ADDR_W-1:0] OFF_INDEX = 12'h030;
  localparam logic [ADDR_W-1:0] OFF_DATA = 12'h034;
  localparam logic [ADDR_W-1:0] OFF_GLOBAL = 12'h038;
  localparam int X_LSB = 0;
  localparam int X_W = 8;
  localparam int SEQ_LSB = 8;
  localparam int SEQ_W = 3;
  localparam int INSERT_BIT = 11;
  localparam int HALF_BIT = 12;
  localparam int GLOBAL_EN_BIT = 0;
  localparam int ENTRIES = 256;
  localparam int SECTIONS = 5;
  localparam int SECT_W = 3;
  localparam int MEM_AW = 11;
  localparam logic [31:0] DATA_RESET = 32'h0000_0000;
  localparam logic [X_W-1:0] X_RESET = 8'h00;
  localparam logic [SEQ_W-1:0] SEQ_RESET = 3'h0;
  localparam int PATH_W_DEFAULT = 32;
endpackage : ctrl_word_tx_pkg

// ===== ctrl_word_tx_table.sv
// APB register bank and transmit table for control word insertion
//
// Register access over APB is this design's own decision.
`timescale 1ns/10ps
`default_nettype none
module ctrl_word_tx_table #(
  parameter int PATH_W = ctrl_word_tx_pkg::PATH_W_DEFAULT
) (
  input wire logic clk_sys,
  input wire logic rst,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [ctrl_word_tx_pkg::ADDR_W-1:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic frame_req,
  input wire logic [7:0] frame_x,
  input wire logic [2:0] frame_sect,
  output logic frame_valid,
  output logic frame_insert,
  output logic [31:0] frame_data
);
  localparam int AW = ctrl_word_tx_pkg::MEM_AW;

  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_WAIT = 2'b01,
    ST_DONE = 2'b10
  } acc_state_t;

  acc_state_t state;
  logic [7:0] idx_x;
  logic [2:0] idx_seq;
  logic idx_half;
  logic idx_insert;
  logic global_en;
  logic [255:0] insert_tab;
  logic [31:0] read_hold;
  logic sect_ok;
  logic [2:0] sect;
  logic [3:0] sect_raw;
  logic setup_acc;
  logic is_index;
  logic is_data;
  logic is_global;
  logic [AW-1:0] cpu_addr;
  logic [AW-1:0] rd_addr;
  logic [31:0] ram_rd;
  logic ram_we;
  logic cpu_rd_slot;
  logic frame_pend;
  logic frame_ins_q;
  // Table RAM has no reset; unwritten sections must still read as zero
  logic frame_live;
  logic [(1<<AW)-1:0] sect_written;
  logic [31:0] next_index_word;

  assign setup_acc = psel && !penable;
  assign is_index = (paddr == ctrl_word_tx_pkg::OFF_INDEX);
  assign is_data = (paddr == ctrl_word_tx_pkg::OFF_DATA);
  assign is_global = (paddr == ctrl_word_tx_pkg::OFF_GLOBAL);

  // Section number from select field and optional half bit
  always_comb begin
    if (PATH_W == 64) begin
      sect_raw = {idx_seq, idx_half};
    end else begin
      sect_raw = {1'b0, idx_seq};
    end
    sect = sect_raw[2:0];
    sect_ok = (sect_raw < 4'(ctrl_word_tx_pkg::SECTIONS));
  end

  assign cpu_addr = {idx_x, sect};
  assign ram_we = (state == ST_IDLE) && setup_acc && pwrite && is_data
    && sect_ok;
  // Core reads have priority; a bus read waits for a free slot
  assign cpu_rd_slot = !frame_req;
  assign rd_addr = frame_req ? {frame_x, frame_sect} : cpu_addr;

  tx_table_ram #(
    .AW(AW),
    .DW(32)
  ) u_ram (
    .clk_sys(clk_sys),
    .wr_en(ram_we),
    .wr_addr(cpu_addr),
    .wr_data(pwdata),
    .rd_addr(rd_addr),
    .rd_data(ram_rd)
  );

  // One flag per section word, set by its first data write
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      sect_written <= '0;
    end else if (ram_we) begin
      sect_written[cpu_addr] <= 1'b1;
    end
  end

  always_comb begin
    next_index_word = 32'h0000_0000;
    next_index_word[ctrl_word_tx_pkg::X_LSB +: 8] = idx_x;
    next_index_word[ctrl_word_tx_pkg::SEQ_LSB +: 3] = idx_seq;
    next_index_word[ctrl_word_tx_pkg::INSERT_BIT] = idx_insert;
    next_index_word[ctrl_word_tx_pkg::HALF_BIT] = (PATH_W == 64) ?
      idx_half : 1'b0;
  end

  // Index register fields
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      idx_x <= ctrl_word_tx_pkg::X_RESET;
      idx_seq <= ctrl_word_tx_pkg::SEQ_RESET;
      idx_half <= 1'b0;
    end else if (setup_acc && pwrite && is_index && state == ST_IDLE) begin
      idx_x <= pwdata[ctrl_word_tx_pkg::X_LSB +: 8];
      idx_seq <= pwdata[ctrl_word_tx_pkg::SEQ_LSB +: 3];
      if (PATH_W == 64) begin
        idx_half <= pwdata[ctrl_word_tx_pkg::HALF_BIT];
      end
    end
  end

  // Insert bits per entry
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      insert_tab <= '0;
    end else if (setup_acc && pwrite && is_index && state == ST_IDLE) begin
      insert_tab[pwdata[7:0]] <= pwdata[ctrl_word_tx_pkg::INSERT_BIT];
    end
  end

  // Field mirrors the stored bit of the entry now indexed
  assign idx_insert = insert_tab[idx_x];

  always_ff @(posedge clk_sys) begin
    if (rst) begin
      global_en <= 1'b0;
    end else if (setup_acc && pwrite && is_global && state == ST_IDLE) begin
      global_en <= pwdata[ctrl_word_tx_pkg::GLOBAL_EN_BIT];
    end
  end

  // Access sequencer: data reads take the table read latency
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      state <= ST_IDLE;
    end else begin
      case (state)
        ST_IDLE: begin
          if (setup_acc && is_data && !pwrite) begin
            state <= ST_WAIT;
          end else if (setup_acc) begin
            state <= ST_DONE;
          end
        end
        ST_WAIT: begin
          if (cpu_rd_slot) begin
            state <= ST_DONE;
          end
        end
        ST_DONE: begin
          if (pready) begin
            state <= ST_IDLE;
          end
        end
        default: begin
          state <= ST_IDLE;
        end
      endcase
    end
  end

  logic wait_rd;

  always_ff @(posedge clk_sys) begin
    if (rst) begin
      wait_rd <= 1'b0;
    end else begin
      wait_rd <= (state == ST_WAIT) && cpu_rd_slot;
    end
  end

  // Read data capture
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      read_hold <= ctrl_word_tx_pkg::DATA_RESET;
    end else if (state == ST_IDLE && setup_acc && !pwrite) begin
      if (is_index) begin
        read_hold <= next_index_word;
      end else if (is_global) begin
        read_hold <= {31'h0000_0000, global_en};
      end else begin
        read_hold <= 32'h0000_0000;
      end
    end else if (wait_rd) begin
      read_hold <= (sect_ok && sect_written[cpu_addr]) ? ram_rd :
        32'h0000_0000;
    end
  end

  // Data read completes after the captured word settles
  assign pready = (state == ST_DONE) && penable && !wait_rd;
  assign prdata = read_hold;
  assign pslverr = 1'b0;

  // Core side lookup: one cycle of table latency
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      frame_pend <= 1'b0;
      frame_ins_q <= 1'b0;
      frame_live <= 1'b0;
    end else begin
      frame_pend <= frame_req;
      frame_live <= frame_req && sect_written[{frame_x, frame_sect}];
      frame_ins_q <= frame_req && insert_tab[frame_x] && global_en;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (rst) begin
      frame_valid <= 1'b0;
      frame_insert <= 1'b0;
      frame_data <= ctrl_word_tx_pkg::DATA_RESET;
    end else begin
      frame_valid <= frame_pend;
      frame_insert <= frame_pend && frame_ins_q;
      frame_data <= (frame_pend && frame_live) ? ram_rd :
        32'h0000_0000;
    end
  end

  property p_data_read_wait;
    @(posedge clk_sys) disable iff (rst)
      (state == ST_IDLE && setup_acc && is_data && !pwrite) |=>
        !pready ##1 !pready;
  endproperty
  a_data_read_wait: assert property (p_data_read_wait)
    else $error("data read answered too soon");

  property p_other_ack;
    @(posedge clk_sys) disable iff (rst)
      (state == ST_IDLE && setup_acc && !(is_data && !pwrite)) |=>
        state == ST_DONE;
  endproperty
  a_other_ack: assert property (p_other_ack)
    else $error("register access not acknowledged");

  property p_frame_valid;
    @(posedge clk_sys) disable iff (rst)
      frame_req |-> ##2 frame_valid;
  endproperty
  a_frame_valid: assert property (p_frame_valid)
    else $error("core lookup not answered");

  property p_global_write;
    @(posedge clk_sys) disable iff (rst)
      (state == ST_IDLE && setup_acc && pwrite && is_global) |=>
        global_en == $past(pwdata[0]);
  endproperty
  a_global_write: assert property (p_global_write)
    else $error("global enable not loaded");

  property p_fresh_zero;
    @(posedge clk_sys) disable iff (rst)
      (frame_pend && !frame_live) |=> frame_data == 32'h0000_0000;
  endproperty
  a_fresh_zero: assert property (p_fresh_zero)
    else $error("unwritten section not zero");

  property p_insert_gate;
    @(posedge clk_sys) disable iff (rst)
      frame_req ##2 frame_valid |-> frame_insert ==
        $past(insert_tab[frame_x] && global_en, 2);
  endproperty
  a_insert_gate: assert property (p_insert_gate)
    else $error("insert decision wrong");

  property p_insert_store;
    @(posedge clk_sys) disable iff (rst)
      (state == ST_IDLE && setup_acc && pwrite && is_index) |=>
        insert_tab[$past(pwdata[7:0])] == $past(pwdata[11]);
  endproperty
  a_insert_store: assert property (p_insert_store)
    else $error("insert bit not stored");

  property p_index_write;
    @(posedge clk_sys) disable iff (rst)
      (state == ST_IDLE && setup_acc && pwrite && is_index) |=>
        idx_x == $past(pwdata[7:0]) && idx_seq == $past(pwdata[10:8]);
  endproperty
  a_index_write: assert property (p_index_write)
    else $error("index fields not loaded");

  property p_mirror;
    @(posedge clk_sys) disable iff (rst)
      $changed(idx_x) |-> next_index_word[11] == insert_tab[idx_x];
  endproperty
  a_mirror: assert property (p_mirror)
    else $error("stale insert bit shown");

  property p_half_zero;
    @(posedge clk_sys) disable iff (rst)
      (PATH_W != 64) |-> idx_half == 1'b0 && next_index_word[12] == 1'b0;
  endproperty
  a_half_zero: assert property (p_half_zero)
    else $error("half bit live at 32-bit width");

  property p_sect_map;
    @(posedge clk_sys) disable iff (rst)
      sect_raw == ((PATH_W == 64) ? {idx_seq, idx_half} : {1'b0, idx_seq});
  endproperty
  a_sect_map: assert property (p_sect_map)
    else $error("section mapping wrong");

  property p_no_write_past_five;
    @(posedge clk_sys) disable iff (rst)
      ram_we |-> sect < 3'(ctrl_word_tx_pkg::SECTIONS);
  endproperty
  a_no_write_past_five: assert property (p_no_write_past_five)
    else $error("write beyond fifth section");

  property p_read_ends;
    @(posedge clk_sys) disable iff (rst)
      (state == ST_WAIT && cpu_rd_slot) |-> ##[1:3] state != ST_WAIT;
  endproperty
  a_read_ends: assert property (p_read_ends)
    else $error("data read stuck");

  c_data_write: cover property (@(posedge clk_sys) disable iff (rst)
    ram_we);
  c_data_read: cover property (@(posedge clk_sys) disable iff (rst)
    state == ST_WAIT ##1 state == ST_DONE);
  c_inserted: cover property (@(posedge clk_sys) disable iff (rst)
    frame_insert);
  c_read_blocked: cover property (@(posedge clk_sys) disable iff (rst)
    state == ST_WAIT && frame_req);
endmodule : ctrl_word_tx_table
`default_nettype wire

// ===== ctrl_word_tx_table_access_bench.sv
// Self-checking bench for the transmit table register bank
`timescale 1ns/10ps
`default_nettype none
module ctrl_word_tx_table_access_bench;
  localparam logic [11:0] IDX = ctrl_word_tx_pkg::OFF_INDEX;
  localparam logic [11:0] DAT = ctrl_word_tx_pkg::OFF_DATA;
  localparam logic [11:0] GLB = ctrl_word_tx_pkg::OFF_GLOBAL;
  logic clk_sys, rst, psel, penable, pwrite, pready, pslverr;
  logic frame_req, frame_valid, frame_insert, glob, pins;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, frame_data, rd, lfsr, r, d, pdata;
  logic [7:0] frame_x;
  logic [2:0] frame_sect;
  logic [31:0] mem [256][8];
  int errors, comparisons, cycles, seen, total;
  int qx[$];
  int qs[$];
  ctrl_word_tx_table dut (.clk_sys(clk_sys), .rst(rst), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .frame_req(frame_req), .frame_x(frame_x), .frame_sect(frame_sect),
    .frame_valid(frame_valid), .frame_insert(frame_insert),
    .frame_data(frame_data));
  frame_core_model core (.clk_sys(clk_sys), .frame_req(frame_req),
    .frame_x(frame_x), .frame_sect(frame_sect));
  function automatic logic [31:0] rnd();
    lfsr = {lfsr[30:0], lfsr[31] ^ lfsr[21] ^ lfsr[1] ^ lfsr[0]};
    return lfsr;
  endfunction : rnd
  function automatic logic [31:0] idx_word(logic [7:0] x,
                                           logic [2:0] s, logic i);
    return {20'h00000, i, s, x};
  endfunction : idx_word
  task automatic chk(string n, logic [31:0] got, logic [31:0] exp);
    comparisons++;
    if (got !== exp) begin
      errors++;
      $display("wrong value %s expected %h seen %h", n, exp, got);
    end
  endtask : chk
  task automatic stop_test();
    if (errors == 0 && comparisons > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask : stop_test
  // Idle edge at the end keeps back-to-back calls from double driving
  task automatic apb(logic w, logic [11:0] a, logic [31:0] v);
    int n;
    n = 0;
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= v;
    @(posedge clk_sys);
    penable <= 1'b1;
    @(posedge clk_sys);
    while (pready !== 1'b1 && n < 100) begin
      @(posedge clk_sys);
      n++;
    end
    if (n == 100) errors++;
    rd = prdata;
    chk("slave error", {31'h0, pslverr}, 32'h0);
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge clk_sys);
  endtask : apb
  always @(negedge clk_sys) begin
    if (frame_valid === 1'b1) begin
      seen++;
      chk("frame data", frame_data, pdata);
      chk("frame insert", {31'h0, frame_insert}, {31'h0, pins & glob});
    end
  end
  always @(posedge clk_sys) begin
    cycles++;
    if (cycles == 20000) begin
      errors++;
      stop_test();
    end
  end
  initial begin
    clk_sys = 1'b0;
    forever #5 clk_sys = ~clk_sys;
  end
  initial begin
    {rst, psel, penable, pwrite, glob, pins} = 6'h20;
    paddr = 12'h000;
    pwdata = 32'h0;
    pdata = 32'h0;
    lfsr = 32'h3B27B3F2;
    {errors, comparisons, cycles, seen, total} = '0;
    foreach (mem[i, j]) mem[i][j] = 32'h0;
    repeat (16) @(posedge clk_sys);
    rst <= 1'b0;
    @(posedge clk_sys);
    apb(1'b0, IDX, 32'h0);
    chk("index reset", rd, 32'h0);
    apb(1'b0, DAT, 32'h0);
    chk("data reset", rd, ctrl_word_tx_pkg::DATA_RESET);
    apb(1'b0, 12'h07C, 32'h0);
    chk("unmapped", rd, 32'h0);
    for (int k = 0; k < 48; k++) begin
      r = rnd();
      d = rnd();
      // Corner entries 0 and 255, and the fifth section
      if (k < 2) r[7:0] = {8{k[0]}};
      if (k == 2) r[10:8] = 3'h4;
      apb(1'b1, IDX, {19'h0, r[12:0]});
      apb(1'b0, IDX, 32'h0);
      chk("index", rd, idx_word(r[7:0], r[10:8], r[11]));
      apb(1'b1, DAT, d);
      pins = r[11];
      pdata = (r[10:8] < 3'h5) ? d : 32'h0;
      mem[r[7:0]][r[10:8]] = pdata;
      qx.push_back(int'(r[7:0]));
      qs.push_back(int'(r[10:8]));
      if (k % 4 == 0) begin
        glob = r[13];
        apb(1'b1, GLB, {31'h0, glob});
      end
      // Core request held while the bus read waits behind it
      if (r[10:8] < 3'h5) begin
        total += k % 3 + 1;
        fork
          core.ask(r[7:0], r[10:8], k % 3 + 1);
          apb(1'b0, DAT, 32'h0);
        join
      end else begin
        apb(1'b0, DAT, 32'h0);
      end
      chk("data", rd, pdata);
      repeat (4) @(posedge clk_sys);
    end
    chk("frame count", 32'(seen), 32'(total));
    foreach (qx[j]) begin
      apb(1'b1, IDX, idx_word(8'(qx[j]), 3'(qs[j]), 1'b0));
      apb(1'b0, DAT, 32'h0);
      chk("stored", rd, mem[qx[j]][qs[j]]);
    end
    stop_test();
  end
endmodule : ctrl_word_tx_table_access_bench
`default_nettype wire

// ===== frame_core_model.sv
// Core transmit path model that asks the table for entries
`timescale 1ns/10ps
`default_nettype none
module frame_core_model (
  input wire logic clk_sys,
  output logic frame_req,
  output logic [7:0] frame_x,
  output logic [2:0] frame_sect
);
  initial frame_req = 1'b0;
  initial frame_x = 8'h00;
  initial frame_sect = 3'h0;
  // Released lines invert so a stale value never matches
  task automatic ask(input logic [7:0] x, input logic [2:0] s,
                     input int n);
    frame_req <= 1'b1;
    frame_x <= x;
    frame_sect <= s;
    repeat (n) @(posedge clk_sys);
    frame_req <= 1'b0;
    frame_x <= ~x;
    frame_sect <= ~s;
  endtask : ask
endmodule : frame_core_model
`default_nettype wire

// ===== tx_table_ram.sv
// Section storage of the transmit table, one write and one read port
`timescale 1ns/10ps
`default_nettype none
module tx_table_ram #(
  parameter int AW = 11,
  parameter int DW = 32
) (
  input wire logic clk_sys,
  input wire logic wr_en,
  input wire logic [AW-1:0] wr_addr,
  input wire logic [DW-1:0] wr_data,
  input wire logic [AW-1:0] rd_addr,
  output logic [DW-1:0] rd_data
);
  logic [DW-1:0] mem [0:(1<<AW)-1];

  always_ff @(posedge clk_sys) begin
    if (wr_en) begin
      mem[wr_addr] <= wr_data;
    end
  end

  // Registered read; write-then-read of the same word sees new data next
  always_ff @(posedge clk_sys) begin
    rd_data <= mem[rd_addr];
  end
endmodule : tx_table_ram
`default_nettype wire
